// ### design/isc_i2c_stop.sv
// Serial port master core: APB registers, byte timing on the baud counter,
// stop sequence with bus collision checks, and start/stop detection.
// Assumes open-drain SDA/SCL resolved outside, and APB on core_clk.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "isc_defs.svh"

module isc_i2c_stop (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // I2C open-drain lines
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // SPI master pins
  output logic             spi_sck,
  output logic             spi_sdo,
  input  wire logic        spi_sdi,
  // Slave addressing logic
  input  wire logic        slave_addr_match,
  input  wire logic        slave_addr_rw,
  input  wire logic        slave_nack,
  input  wire logic        addr_update_req,
  // Pad configuration
  output logic             slew_rate_ctrl_en,
  output logic             smbus_thresh_en,
  output logic             spi_sample_at_end,
  output logic             spi_shift_active_to_idle
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    isc_pkg::isc_state_t state;
    logic [7:0]          baud_reload_address;
    logic [7:0]          serial_data_buffer;
    logic [7:0]          serial_control_one;
    logic [7:0]          serial_control_two;
    logic [7:0]          serial_control_three;
    logic [7:0]          address_compare_mask;
    logic [7:0]          shreg;
    logic [3:0]          bitcnt;
    logic                rx;
    logic                ld;
    logic                sample_slew_select;
    logic                edge_select;
    logic                data_not_addr;
    logic                stop_seen;
    logic                start_seen;
    logic                slave_rw;
    logic                tx_busy;
    logic                address_update_needed;
    logic                buffer_full_flag;
    logic                first_byte;
    logic                bus_collision_flag;
    logic                serial_port_irq_flag;
    logic                scl_hold;
    logic                scl_drv;
    logic                sda_drv;
    logic                sck;
    logic                sda_prev;
    logic [31:0]         rdata;
  } isc_st_t;

  isc_st_t      q;
  isc_st_t      next_q;
  logic [2:0]   pins_s;
  logic         scl_s;
  logic         sda_s;
  logic         sdi_s;
  logic         i2c_mode;
  logic         i2c_master;
  logic         spi_mode;
  logic         port_en;
  logic         port_idle;
  logic         wr_acc;
  logic         rd_acc;
  logic         collide;
  logic [7:0]   status_byte;
  logic [31:0]  rd_mux;

  isc_baud_if bctl ();

  isc_sync u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .pin_in   ({spi_sdi, sda_i, scl_i}),
    .pin_sync (pins_s)
  );

  isc_baud u_baud (
    .core_clk (core_clk),
    .srst     (srst),
    .bctl     (bctl)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign sdi_s = pins_s[2];

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'b00) && (a <= `ISC_OFS_FLAGS);
  endfunction

  function automatic logic is_i2c(input logic [3:0] m);
    is_i2c = (m[3:1] == 3'b011) || (m == 4'h8) || (m == 4'hb) || (m[3:1] == 3'b111);
  endfunction

  assign port_en    = q.serial_control_one[`ISC_C1_EN];
  assign i2c_mode   = port_en & is_i2c(q.serial_control_one[3:0]);
  assign i2c_master = port_en & (q.serial_control_one[3:0] == `ISC_MODE_I2C_MST);
  assign spi_mode   = port_en & ~is_i2c(q.serial_control_one[3:0]);
  assign port_idle  = (q.state == isc_pkg::ST_IDLE) && !q.tx_busy &&
                      (q.serial_control_two[4:0] == 5'b00000);

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  // Bit 2 means transmit busy as master, last direction as slave
  assign status_byte = {q.sample_slew_select, q.edge_select, q.data_not_addr,
                        q.stop_seen, q.start_seen,
                        i2c_master ? q.tx_busy : q.slave_rw,
                        q.address_update_needed, q.buffer_full_flag};

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `ISC_OFS_RELOAD: rd_mux[7:0] = q.baud_reload_address;
      `ISC_OFS_BUFFER: rd_mux[7:0] = q.serial_data_buffer;
      `ISC_OFS_CTRL1:  rd_mux[7:0] = q.serial_control_one;
      `ISC_OFS_CTRL2:  rd_mux[7:0] = q.serial_control_two;
      `ISC_OFS_CTRL3:  rd_mux[7:0] = q.serial_control_three;
      `ISC_OFS_MASK:   rd_mux[7:0] = q.address_compare_mask;
      `ISC_OFS_STATUS: rd_mux[7:0] = status_byte;
      `ISC_OFS_FLAGS:  rd_mux[1:0] = {q.bus_collision_flag, q.serial_port_irq_flag};
      default:         rd_mux      = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_q    = q;
    next_q.ld = 1'b0;
    collide   = 1'b0;
    next_q.sda_prev = sda_s;

    // Read data is captured in the setup phase so prdata comes from a flop
    if (psel && !penable) begin
      next_q.rdata = rd_mux;
    end

    // Software side first, so that hardware sets below win over clears
    if (wr_acc) begin
      unique case (paddr)
        `ISC_OFS_RELOAD: begin
          next_q.baud_reload_address   = pwdata[7:0];
          next_q.address_update_needed = 1'b0;
        end
        `ISC_OFS_BUFFER: begin
          if (port_idle && (i2c_master || spi_mode)) begin
            next_q.serial_data_buffer = pwdata[7:0];
            next_q.shreg              = pwdata[7:0];
            next_q.buffer_full_flag   = i2c_master;
            next_q.tx_busy            = i2c_master;
            next_q.rx                 = 1'b0;
            next_q.bitcnt             = 4'h0;
            next_q.state              = isc_pkg::ST_B_LOW;
            next_q.ld                 = 1'b1;
          end else begin
            next_q.serial_control_one[`ISC_C1_WCOL] = 1'b1;
          end
        end
        `ISC_OFS_CTRL1: begin
          next_q.serial_control_one = {q.serial_control_one[7:6] & pwdata[7:6],
                                       pwdata[5:0]};
        end
        `ISC_OFS_CTRL2: begin
          // Sequence enables can only be set, and only while idle
          next_q.serial_control_two = {pwdata[7], q.serial_control_two[6], pwdata[5],
                                       q.serial_control_two[4:0] |
                                       (port_idle ? pwdata[4:0] : 5'b00000)};
        end
        `ISC_OFS_CTRL3:  next_q.serial_control_three = {q.serial_control_three[7], pwdata[6:0]};
        `ISC_OFS_MASK:   next_q.address_compare_mask = pwdata[7:0];
        `ISC_OFS_STATUS: begin
          next_q.sample_slew_select = pwdata[7];
          next_q.edge_select        = pwdata[6];
        end
        `ISC_OFS_FLAGS: begin
          next_q.serial_port_irq_flag = q.serial_port_irq_flag & ~pwdata[`ISC_FL_SERIAL];
          next_q.bus_collision_flag   = q.bus_collision_flag & ~pwdata[`ISC_FL_BUSCOL];
        end
        default: ;
      endcase
    end
    if (rd_acc && (paddr == `ISC_OFS_BUFFER) && q.rx) begin
      next_q.buffer_full_flag = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Bus monitor
    // ----------------------------------------------------------------------
    if (i2c_mode && scl_s && q.sda_prev && !sda_s) begin
      next_q.start_seen = 1'b1;
      next_q.stop_seen  = 1'b0;
      next_q.slave_rw   = 1'b0;
      next_q.first_byte = 1'b1;
    end
    if (i2c_mode && scl_s && !q.sda_prev && sda_s) begin
      next_q.stop_seen  = 1'b1;
      next_q.start_seen = 1'b0;
      next_q.slave_rw   = 1'b0;
    end
    if (slave_nack) begin
      next_q.slave_rw = 1'b0;
    end
    if (slave_addr_match) begin
      next_q.slave_rw = slave_addr_rw;
    end
    if (addr_update_req) begin
      next_q.address_update_needed = 1'b1;
    end

    // ----------------------------------------------------------------------
    // Byte engine and stop sequence
    // ----------------------------------------------------------------------
    unique case (q.state)
      isc_pkg::ST_IDLE: begin
        if (i2c_master && q.serial_control_two[`ISC_C2_STOP]) begin
          next_q.state    = isc_pkg::ST_P_LOW;
        end else if (i2c_master && q.serial_control_two[`ISC_C2_RECV]) begin
          next_q.state    = isc_pkg::ST_B_LOW;
          next_q.rx       = 1'b1;
          next_q.bitcnt   = 4'h0;
          next_q.ld       = 1'b1;
        end
      end
      isc_pkg::ST_B_LOW: begin
        if (bctl.timeout) begin
          next_q.state = isc_pkg::ST_B_HIGH;
        end
      end
      isc_pkg::ST_B_HIGH: begin
        if (bctl.timeout) begin
          next_q.bitcnt = q.bitcnt + 4'h1;
          next_q.state  = isc_pkg::ST_B_LOW;
          next_q.shreg  = {q.shreg[6:0], spi_mode ? sdi_s : sda_s};
          if (q.bitcnt == `ISC_ACK_BIT) begin
            // Ninth clock: acknowledge sampled, SCL stays low
            next_q.serial_control_two[`ISC_C2_ACKSTAT] = sda_s;
            next_q.state                = isc_pkg::ST_IDLE;
            next_q.tx_busy              = 1'b0;
            next_q.serial_port_irq_flag = 1'b1;
            next_q.data_not_addr        = ~q.first_byte;
            next_q.first_byte           = 1'b0;
            next_q.scl_hold             = 1'b1;
            next_q.shreg                = q.shreg;
          end else if (q.bitcnt == `ISC_LAST_BIT) begin
            if (q.rx || spi_mode) begin
              // Receive done: buffer full, overflow if still unread on an I2C receive (never in SPI mode)
              next_q.serial_control_one[`ISC_C1_OV] =
                q.serial_control_one[`ISC_C1_OV] | (q.buffer_full_flag & q.rx);
              next_q.serial_data_buffer   = {q.shreg[6:0], spi_mode ? sdi_s : sda_s};
              next_q.buffer_full_flag     = 1'b1;
              next_q.rx                   = ~spi_mode;
              next_q.data_not_addr        = q.rx ? 1'b1 : q.data_not_addr;
              next_q.serial_control_two[`ISC_C2_RECV] = 1'b0;
              next_q.serial_port_irq_flag = 1'b1;
              next_q.state                = isc_pkg::ST_IDLE;
              next_q.scl_hold             = ~spi_mode;
            end else begin
              next_q.buffer_full_flag = 1'b0; // Data bits out, ack excluded
            end
          end
        end
      end
      isc_pkg::ST_P_LOW: begin
        if (!sda_s) begin
          next_q.state = isc_pkg::ST_P_SCL;
        end
      end
      isc_pkg::ST_P_SCL: begin
        if (scl_s) begin
          next_q.state = isc_pkg::ST_P_HOLD; // Counter loaded while SCL was low
        end
      end
      isc_pkg::ST_P_HOLD: begin
        if (!scl_s) begin
          collide = 1'b1;
        end else if (bctl.timeout) begin
          next_q.state = isc_pkg::ST_P_REL;
        end
      end
      isc_pkg::ST_P_REL: begin
        if (!scl_s && !sda_s) begin
          collide = 1'b1;
        end else if (bctl.timeout) begin
          if (!sda_s) begin
            collide = 1'b1; // Another master holds SDA low
          end else begin
            next_q.state = isc_pkg::ST_P_DONE;
          end
        end
      end
      isc_pkg::ST_P_DONE: begin
        if (bctl.timeout) begin
          next_q.state                            = isc_pkg::ST_IDLE;
          next_q.serial_control_two[`ISC_C2_STOP] = 1'b0;
          next_q.serial_port_irq_flag             = 1'b1;
          next_q.scl_hold                         = 1'b0;
        end
      end
    endcase

    if (next_q.state == isc_pkg::ST_B_LOW && q.state != isc_pkg::ST_B_LOW) begin
      next_q.scl_hold = 1'b0;
    end

    // Any collision aborts everything and lets go of both lines
    if (collide) begin
      next_q.bus_collision_flag       = 1'b1;
      next_q.state                    = isc_pkg::ST_IDLE;
      next_q.serial_control_two[4:0]  = 5'b00000;
      next_q.scl_hold                 = 1'b0;
      next_q.tx_busy                  = 1'b0;
      next_q.buffer_full_flag         = q.buffer_full_flag & ~q.tx_busy;
    end

    // Disabling the port idles it and forgets start/stop history
    if (!next_q.serial_control_one[`ISC_C1_EN]) begin
      next_q.state      = isc_pkg::ST_IDLE;
      next_q.stop_seen  = 1'b0;
      next_q.start_seen = 1'b0;
      next_q.scl_hold   = 1'b0;
      next_q.tx_busy    = 1'b0;
      next_q.serial_control_two[4:0] = 5'b00000;
    end

    // Line drive follows the next state, so pins come straight from flops
    unique case (next_q.state)
      isc_pkg::ST_IDLE: begin
        next_q.scl_drv = next_q.scl_hold;
        next_q.sda_drv = 1'b0;
      end
      isc_pkg::ST_B_LOW, isc_pkg::ST_B_HIGH: begin
        next_q.scl_drv = i2c_mode && (next_q.state == isc_pkg::ST_B_LOW);
        next_q.sda_drv = i2c_mode && !next_q.rx && (next_q.bitcnt != `ISC_ACK_BIT) &&
                         !next_q.shreg[7];
      end
      isc_pkg::ST_P_LOW: begin
        next_q.scl_drv = 1'b1;
        next_q.sda_drv = 1'b1;
      end
      isc_pkg::ST_P_SCL, isc_pkg::ST_P_HOLD: begin
        next_q.scl_drv = 1'b0;
        next_q.sda_drv = 1'b1;
      end
      isc_pkg::ST_P_REL, isc_pkg::ST_P_DONE: begin
        next_q.scl_drv = 1'b0;
        next_q.sda_drv = 1'b0;
      end
    endcase
    next_q.sck = q.serial_control_one[`ISC_C1_CKP] ^ (next_q.state == isc_pkg::ST_B_LOW);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q          <= '0;
      q.sda_prev <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Baud counter control
  // ----------------------------------------------------------------------
  // Holding load while SCL is low stretches the high half
  assign bctl.reload = q.baud_reload_address;
  assign bctl.run    = (q.state != isc_pkg::ST_IDLE);
  assign bctl.load   = q.ld || (i2c_mode && !scl_s &&
                       (q.state == isc_pkg::ST_B_HIGH || q.state == isc_pkg::ST_P_SCL));

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata  = q.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~reg_hit(paddr);
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign scl_oe  = q.scl_drv;
  assign sda_oe  = q.sda_drv;
  assign spi_sck = spi_mode ? q.sck : q.serial_control_one[`ISC_C1_CKP];
  assign spi_sdo = q.shreg[7];

  assign slew_rate_ctrl_en        = i2c_mode & ~q.sample_slew_select;
  assign smbus_thresh_en          = i2c_mode & q.edge_select;
  assign spi_sample_at_end        = spi_mode & q.sample_slew_select;
  assign spi_shift_active_to_idle = spi_mode & q.edge_select;

endmodule

`default_nettype wire

// ### design/isc_defs.svh
// Register offsets, field positions, mode codes and reset values for the
// stop-collision and baud counter block.
// Assumes byte addresses on a 32-bit APB with one register per word.
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ISC_OFS_RELOAD  8'h00
`define ISC_OFS_BUFFER  8'h04
`define ISC_OFS_CTRL1   8'h08
`define ISC_OFS_CTRL2   8'h0c
`define ISC_OFS_CTRL3   8'h10
`define ISC_OFS_MASK    8'h14
`define ISC_OFS_STATUS  8'h18
`define ISC_OFS_FLAGS   8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ISC_C1_WCOL     7
`define ISC_C1_OV       6
`define ISC_C1_EN       5
`define ISC_C1_CKP      4
`define ISC_C2_ACKSTAT  6
`define ISC_C2_ACK_SEQ  4
`define ISC_C2_RECV     3
`define ISC_C2_STOP     2
`define ISC_FL_SERIAL   0
`define ISC_FL_BUSCOL   1

// ----------------------------------------------------------------------
// Mode codes and counts
// ----------------------------------------------------------------------
`define ISC_MODE_I2C_MST  4'h8
`define ISC_MODE_SPI_BAUD 4'ha
`define ISC_LAST_BIT      4'h7
`define ISC_ACK_BIT       4'h8
`define ISC_RESET_BYTE    8'h00

`endif

// ### design/isc_pkg.sv
// Types shared by the stop-collision and baud counter block.
// Assumes the constants of isc_defs.svh are included where needed.
package isc_pkg;

  // Byte engine and stop sequence states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_B_LOW  = 3'b001,
    ST_B_HIGH = 3'b010,
    ST_P_LOW  = 3'b011,
    ST_P_SCL  = 3'b100,
    ST_P_HOLD = 3'b101,
    ST_P_REL  = 3'b110,
    ST_P_DONE = 3'b111
  } isc_state_t;

endpackage

// ### design/isc_brg_if.sv
// Control bundle between the serial port core and its baud counter.
// Assumes both ends run on core_clk.
`timescale 1ns/100ps
`default_nettype none

interface isc_baud_if;
  logic       load;
  logic       run;
  logic [7:0] reload;
  logic       timeout;

  modport ctl (output load, output run, output reload, input timeout);
  modport cnt (input load, input run, input reload, output timeout);
endinterface

`default_nettype wire

// ### design/isc_sync.sv
// Two-flop synchroniser for the bus and serial input pins.
// Assumes asynchronous pin levels and a single core_clk domain.
`timescale 1ns/100ps
`default_nettype none

module isc_sync (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Pins in, synchronised levels out
  input  wire logic [2:0] pin_in,
  output logic      [2:0] pin_sync
);

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } isc_sync_st_t;

  isc_sync_st_t q;
  isc_sync_st_t next_q;

  // First stage feeds only the second stage
  always_comb begin
    next_q.stage1 = pin_in;
    next_q.stage2 = q.stage1;
  end

  // Released lines idle high, so reset to ones to avoid false edges
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '1;
    end else begin
      q <= next_q;
    end
  end

  assign pin_sync = q.stage2;

endmodule

`default_nettype wire

// ### design/isc_baud.sv
// Reload-based baud counter: counts the reload value down to zero at half
// the core rate, reloading itself at every rollover while it runs.
// Assumes the controller holds load while a count must not yet start.
`timescale 1ns/100ps
`default_nettype none

module isc_baud (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Control bundle
  isc_baud_if.cnt   bctl
);

  typedef struct packed {
    logic [7:0] count;
    logic       half;
  } isc_baud_st_t;

  isc_baud_st_t q;
  isc_baud_st_t next_q;
  logic         tick;

  // Counting at half the core rate makes one rollover 2*(n+1) cycles
  assign tick         = q.half;
  assign bctl.timeout = bctl.run & ~bctl.load & tick & (q.count == 8'h00);

  always_comb begin
    next_q = q;
    if (bctl.load) begin
      next_q.count = bctl.reload;
      next_q.half  = 1'b0;
    end else if (bctl.run) begin // Stops by itself when idle
      next_q.half = ~q.half;
      if (tick) begin
        // Rollover reloads from the reload register
        next_q.count = (q.count == 8'h00) ? bctl.reload : q.count - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

`default_nettype wire

// ### dv/isc_bus_model.sv
// Other bus parties: pull-ups on both lines and a master that can hold them low.
// Assumes the open-drain enables of the design, one clock domain.
`timescale 1ns/100ps
`default_nettype none

module isc_bus_model (
  // Design drive
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // Fault commands from the bench
  input  wire logic hold_sda,
  input  wire logic pull_scl,
  // Resolved lines
  output logic      scl,
  output logic      sda
);
  // Wired-AND with pull-ups, so a released line reads high unless someone holds it
  assign scl = !(scl_oe || pull_scl);
  assign sda = !(sda_oe || hold_sda);
endmodule

`default_nettype wire

// ### dv/isc_props_props.sv
// Port checks for the serial port master core.
// Assumes bind into isc_i2c_stop; srst synchronous.
`timescale 1ns/100ps
`default_nettype none

module isc_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Lines and pads
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        sda_i,
  input wire logic        spi_sck,
  input wire logic        slew_rate_ctrl_en,
  input wire logic        smbus_thresh_en
);
  logic cfg_wr;
  assign cfg_wr = psel && penable && pwrite && (paddr == 8'h18 || paddr == 8'h08);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence acc_s; psel && penable; endsequence
  sequence rd_s; acc_s ##0 !pwrite; endsequence
  chk_ready_const: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (acc_s ##0 paddr > 8'h1c |-> pslverr) else $error("no err");
  chk_err_zero: assert property (rd_s ##0 pslverr |-> prdata == 32'h0) else $error("err data");
  chk_read_upper: assert property (rd_s |-> prdata[31:8] == 24'h0) else $error("upper bits");
  chk_lines_free: assert property ($fell(srst) |-> !scl_oe && !sda_oe) else $error("driven");
  chk_scl_after_sda: assert property ($fell(scl_oe) && sda_oe |-> !$past(sda_i, 2))
    else $error("scl early");
  chk_pads_by_write: assert property ($changed({slew_rate_ctrl_en, smbus_thresh_en})
    |-> $past(cfg_wr)) else $error("pad moved");
  chk_sck_half: assert property ($changed(spi_sck) && !$past(cfg_wr)
    |=> $stable(spi_sck)[*3]) else $error("sck short");
endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench: APB tasks, stop sequences with collisions, pads, baud timing.
// Assumes design/ on the include path and isc_bus_model on the lines.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, scl, sda, scl_oe, sda_oe, sck, slew, smb, samp, shft, sdo;
  logic        hold_sda = 0, pull_scl = 0, upd = 0;
  int          bad_count = 0, checked = 0, cyc = 0;

  isc_i2c_stop isc_i2c_stop_i (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(),
    .sda_oe, .spi_sck(sck), .spi_sdo(sdo), .spi_sdi(1'b0), .slave_addr_match(1'b0),
    .slave_addr_rw(1'b0), .slave_nack(1'b0), .addr_update_req(upd),
    .slew_rate_ctrl_en(slew), .smbus_thresh_en(smb), .spi_sample_at_end(samp),
    .spi_shift_active_to_idle(shft));
  isc_bus_model isc_bus_model_i (.scl_oe, .sda_oe, .hold_sda, .pull_scl, .scl, .sda);

  always #5 core_clk = !core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Master holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    @(posedge core_clk);
  endtask

  task automatic t_pads(input logic [7:0] mode, input logic [7:0] st, input logic [3:0] exp);
    apb(1, 8'h08, {24'h0, mode});
    apb(1, 8'h18, {24'h0, st});
    check(32'(mode == 8'h28 ? {slew, smb} : {samp, shft}), 32'(exp[1:0]), "pads");
  endtask

  task automatic t_stop(input logic hs, input logic ps, input logic [31:0] fl);
    apb(1, 8'h1c, 32'h3);
    hold_sda <= hs;
    apb(1, 8'h0c, 32'h4);
    if (ps) begin
      repeat (100) begin
        @(posedge core_clk);
        if (!scl_oe && sda_oe) break;
      end
      repeat (5) @(posedge core_clk);
      pull_scl <= 1;
    end
    repeat (100) begin
      apb(0, 8'h0c, 0);
      if (rd[2] === 1'b0) break;
    end
    check(rd, 32'h0, "stop enable");
    apb(0, 8'h1c, 0);
    check(rd, fl, "flags");
    check(32'({scl_oe, sda_oe}), 32'h0, "lines");
    hold_sda <= 0; pull_scl <= 0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic t_baud;
    int n;
    apb(1, 8'h00, 32'h3);
    apb(1, 8'h08, 32'h2a);
    apb(1, 8'h04, 32'ha5);
    // The first half period carries the load cycle, so time a later one
    n = 0;
    while (sck !== 1'b0 && n < 100) begin @(posedge core_clk); n++; end
    while (sck !== 1'b1 && n < 100) begin @(posedge core_clk); n++; end
    check(32'(sdo), 32'h0, "sdo bit 6");
    n = 0;
    while (sck !== 1'b0 && n < 100) begin @(posedge core_clk); n++; end
    while (sck !== 1'b1 && n < 100) begin @(posedge core_clk); n++; end
    check(n, 32'd16, "sck period");
    check(32'(sdo), 32'h1, "sdo bit 5");
    repeat (300) @(posedge core_clk);
    check(32'(sck), 32'h0, "sck idle");
    apb(0, 8'h18, 0);
    check(rd, 32'h1, "rx full");
  endtask

  task automatic t_tx;
    apb(1, 8'h04, 32'h55);
    apb(0, 8'h18, 0);
    check(rd & 32'h5, 32'h5, "tx busy");
    repeat (250) @(posedge core_clk);
    apb(0, 8'h18, 0);
    check(rd & 32'h5, 32'h0, "tx done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 0;
    @(posedge core_clk);
    apb(0, 8'h18, 0);
    check(rd, 32'h0, "status reset");
    upd <= 1;
    @(posedge core_clk) upd <= 0;
    apb(0, 8'h18, 0);
    check(rd, 32'h2, "update request");
    apb(0, 8'h40, 0);
    check(32'({err, rd[7:0]}), 32'h100, "unmapped");
    t_pads(8'h28, 8'h80, 4'h0);
    t_pads(8'h28, 8'h40, 4'h3);
    t_pads(8'h2a, 8'hc0, 4'h3);
    t_pads(8'h2a, 8'h00, 4'h0);
    t_baud;
    apb(1, 8'h08, 32'h28);
    t_stop(0, 0, 32'h1);
    apb(0, 8'h18, 0);
    check(rd & 32'h18, 32'h10, "stop seen");
    t_stop(1, 0, 32'h2);
    t_stop(0, 1, 32'h2);
    t_tx;
    apb(1, 8'h08, 32'h08);
    apb(0, 8'h18, 0);
    check(rd & 32'h18, 32'h0, "disable clears");
    complete_run();
  end
endmodule

bind isc_i2c_stop isc_props isc_props_i (.core_clk, .srst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .scl_oe, .sda_oe, .sda_i, .spi_sck, .slew_rate_ctrl_en,
  .smbus_thresh_en);

`default_nettype wire
